// ### dsrs_pkg.sv
// constants, fields and helpers for the scratch and memory store
package dsrs_pkg;
    // widths and depths
    localparam int DW = 24;
    localparam int SCR_N = 8;
    localparam int CW = 16;
    localparam int CAW = 8;
    localparam int DAW = 7;
    localparam int UPD_MAX = 16;
    localparam int UPD_CW = 5;
    // pointer start values each sampling cycle
    localparam logic [7:0] CPA_INIT = 8'h00;
    localparam logic [7:0] CPB_INIT = 8'h80;
    localparam logic [6:0] DPA_INIT = 7'h00;
    localparam logic [6:0] DPB_INIT = 7'h40;
    localparam logic [6:0] RING_STEP = 7'h01;
    // bus field positions and fills
    localparam int COEF_MSB = 23;
    localparam int COEF_LSB = 8;
    localparam int DPTR_LSB = 17;
    localparam int CPTR_LSB = 16;
    localparam logic [7:0] COEF_LOW_FILL = 8'h00;
    localparam logic [3:0] SCR_FIRST = 4'h1;
    localparam logic [3:0] SCR_LAST = 4'h8;

    typedef enum logic [3:0] {
        SRC_NONE, SRC_SCR0, SRC_SCR1, SRC_SCR2, SRC_SCR3,
        SRC_SCR4, SRC_SCR5, SRC_SCR6, SRC_SCR7, SRC_COEF, SRC_DATA
    } dsrs_src_t;
    typedef enum logic [3:0] {
        DST_NONE, DST_SCR0, DST_SCR1, DST_SCR2, DST_SCR3,
        DST_SCR4, DST_SCR5, DST_SCR6, DST_SCR7, DST_COEF_WR, DST_DATA_WR,
        DST_LOAD_CPA, DST_LOAD_CPB, DST_LOAD_DPA, DST_LOAD_DPB
    } dsrs_dst_t;
    typedef enum logic [1:0] {CP_NOP, CP_UP, CP_DOWN, CP_SWITCH} dsrs_cptr_t;
    typedef enum logic [2:0] {
        DP_NOP, DP_UP1, DP_UP2, DP_UP3, DP_DN1, DP_DN2, DP_DN3, DP_SWITCH
    } dsrs_dptr_t;

    // field selects one of the scratch registers
    function automatic logic is_scr(input logic [3:0] f);
        return (f >= SCR_FIRST) && (f <= SCR_LAST);
    endfunction
    function automatic logic [2:0] scr_idx(input logic [3:0] f);
        return 3'(f - SCR_FIRST);
    endfunction
    // signed step of the data pointer, two's complement
    function automatic logic [6:0] dp_delta(input dsrs_dptr_t c);
        case (c)
            DP_UP1: return 7'h01;
            DP_UP2: return 7'h02;
            DP_UP3: return 7'h03;
            DP_DN1: return 7'h7F;
            DP_DN2: return 7'h7E;
            DP_DN3: return 7'h7D;
            default: return 7'h00;
        endcase
    endfunction
endpackage

// ### dsrs_mem_if.sv
// memory port bundle between owner and memory
`timescale 1ns/1ns
`default_nettype none
interface dsrs_mem_if #(parameter int AW = 8, parameter int DW = 16);
    logic we;
    logic [AW-1:0] waddr;
    logic [DW-1:0] wdata;
    logic [AW-1:0] raddr;
    logic [DW-1:0] rdata;
    modport owner (output we, output waddr, output wdata, output raddr, input rdata);
    modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// ### dsrs_ram.sv
// single write, single registered read memory with write bypass
`timescale 1ns/1ns
`default_nettype none
module dsrs_ram #(
    parameter int AW = 8,
    parameter int DW = 16
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // memory port
    dsrs_mem_if.mem port
);
    logic [DW-1:0] mem_q [0:(1<<AW)-1];
    logic hit;

    // same-step write to the read address is seen at once
    assign hit = port.we && (port.waddr == port.raddr);

    // storage, contents kept through reset for bulk loading
    always_ff @(posedge sys_clk_i) begin
        if (port.we) begin
            mem_q[port.waddr] <= port.wdata;
        end
    end

    // output register, one step behind the address
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            port.rdata <= '0;
        end else begin
            port.rdata <= hit ? port.wdata : mem_q[port.raddr];
        end
    end
endmodule
`default_nettype wire

// ### dsrs_ptr.sv
// pair of address pointers with step, switch, load and restart
`timescale 1ns/1ns
`default_nettype none
module dsrs_ptr #(
    parameter int AW = 8,
    parameter logic [AW-1:0] RST_A = '0,
    parameter logic [AW-1:0] RST_B = '0
) (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // restart
    input wire logic init_i,
    input wire logic [AW-1:0] init_a_i,
    input wire logic [AW-1:0] init_b_i,
    // commands
    input wire logic step_i,
    input wire logic [AW-1:0] delta_i,
    input wire logic switch_i,
    input wire logic load_a_i,
    input wire logic load_b_i,
    input wire logic [AW-1:0] load_val_i,
    // state
    output logic [AW-1:0] addr_o,
    output logic [AW-1:0] ptr_a_o,
    output logic [AW-1:0] ptr_b_o,
    output logic sel_b_o
);
    logic [AW-1:0] a_q, a_d, b_q, b_d;
    logic sel_q, sel_d, move_a, move_b;
    logic [AW-1:0] inc_a, inc_b;

    // switch bumps the pointer left, step moves the active one
    assign move_a = !sel_q && (step_i || switch_i);
    assign move_b = sel_q && (step_i || switch_i);
    assign inc_a = switch_i ? AW'(a_q + 1'b1) : AW'(a_q + delta_i);
    assign inc_b = switch_i ? AW'(b_q + 1'b1) : AW'(b_q + delta_i);
    // restart first, then load, then movement; sums wrap at depth
    assign a_d = init_i ? init_a_i : load_a_i ? load_val_i : move_a ? inc_a : a_q;
    assign b_d = init_i ? init_b_i : load_b_i ? load_val_i : move_b ? inc_b : b_q;
    assign sel_d = init_i ? 1'b0 : switch_i ? !sel_q : sel_q;
    assign addr_o = sel_q ? b_q : a_q;
    assign ptr_a_o = a_q;
    assign ptr_b_o = b_q;
    assign sel_b_o = sel_q;

    // pointer registers
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            a_q <= RST_A;
            b_q <= RST_B;
            sel_q <= 1'b0;
        end else begin
            a_q <= a_d;
            b_q <= b_d;
            sel_q <= sel_d;
        end
    end
endmodule
`default_nettype wire

// ### dsrs_top.sv
// scratch registers, coefficient memory and data memory of the datapath
// Behaviour
// - eight 24-bit scratch registers load from and drive the shared bus
// - coefficient memory holds 256 words of 16 bits
// - coefficient writes: bulk in reset, 16-word update running, bus write
// - coefficient read feeds multiplier, or bus upper bits with low 8 zero
// - each sampling cycle coefficient pointers go to 0 and 80 hex, first active
// - active coefficient pointer steps +1 or -1; load takes the bus value
// - coefficient switch swaps active pointer and increments the one left
// - coefficient data appears two steps after the pointer operation
// - coefficient bus write uses prior address, readable the next step
// - after a coefficient switch the new pointer drives output two steps on
// - data memory holds 128 words of 24 bits with two pointers
// - data memory written only from bus, read to multiplier and bus
// - linear mode starts data pointers at 00 and 40 hex each cycle
// - ring mode advances start by one per cycle; first pointer active
// - active data pointer steps by plus or minus one, two or three
// - data pointer load adds start address in ring mode, plain in linear
// - data switch swaps active pointer and increments the one left
// - data memory contents appear two steps after the step command
// - data write uses prior address, readable the following step
// - after a data switch the new pointer drives reads two steps on
// - narrow sources on the bus get zero low-order bits
// - no source selected or reset holds the bus at zero
`timescale 1ns/1ns
`default_nettype none
module dsrs_top (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // sampling cycle and mode
    input wire logic sample_start_i,
    input wire logic ring_mode_i,
    // microcode fields
    input wire dsrs_pkg::dsrs_src_t source_select_field_i,
    input wire dsrs_pkg::dsrs_dst_t destination_select_field_i,
    input wire dsrs_pkg::dsrs_cptr_t coef_ptr_cmd_i,
    input wire dsrs_pkg::dsrs_dptr_t data_ptr_cmd_i,
    // shared data bus
    input wire logic [dsrs_pkg::DW-1:0] shared_data_bus_i,
    output logic [dsrs_pkg::DW-1:0] shared_data_bus_o,
    // host coefficient loading
    input wire logic coef_load_we_i,
    input wire logic coef_upd_start_i,
    input wire logic [dsrs_pkg::CAW-1:0] coef_load_addr_i,
    input wire logic [dsrs_pkg::CW-1:0] coefficient_load_bus_i,
    output logic coef_load_ready_o,
    // multiplier operands
    output logic [dsrs_pkg::CW-1:0] multiplier_coef_input_o,
    output logic [dsrs_pkg::DW-1:0] multiplier_data_input_o
);
    import dsrs_pkg::*;

    dsrs_mem_if #(.AW(CAW), .DW(CW)) c_if ();
    dsrs_mem_if #(.AW(DAW), .DW(DW)) d_if ();

    logic [DW-1:0] scr_q [0:SCR_N-1];
    logic [DAW-1:0] base_q, start_q;
    logic [UPD_CW-1:0] upd_cnt_q, upd_cnt_d;
    logic [CAW-1:0] upd_addr_q;
    logic hold_v_q, hold_v_d;
    logic [CAW-1:0] hold_addr_q;
    logic [CW-1:0] hold_data_q;
    logic ready_q;

    // field decode
    logic dst_scr, src_scr, coef_bus_wr, data_bus_wr, bulk_wr, drain;
    logic accept, run_start;
    logic [2:0] dst_sel, src_sel;
    logic [CAW-1:0] caddr, cp_a, cp_b, cp_load, cp_delta;
    logic [DAW-1:0] daddr, dp_a, dp_b, dp_load, dp_init_a, dp_init_b, load_off;
    logic cp_sel_b, dp_sel_b, cp_step, dp_step;
    logic [DW-1:0] scr_out, coef_wide, bus_mux;

    assign dst_scr = resetn_i && is_scr(destination_select_field_i);
    assign src_scr = is_scr(source_select_field_i);
    assign dst_sel = scr_idx(destination_select_field_i);
    assign src_sel = scr_idx(source_select_field_i);
    assign coef_bus_wr = resetn_i && (destination_select_field_i == DST_COEF_WR);
    assign data_bus_wr = resetn_i && (destination_select_field_i == DST_DATA_WR);

    // scratch registers capture the bus when selected as destination
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            for (int i = 0; i < SCR_N; i++) begin
                scr_q[i] <= '0;
            end
        end else if (dst_scr) begin
            scr_q[dst_sel] <= shared_data_bus_i;
        end
    end

    // coefficient pointers: restart, step, switch and load
    assign cp_step = (coef_ptr_cmd_i == CP_UP) || (coef_ptr_cmd_i == CP_DOWN);
    assign cp_delta = (coef_ptr_cmd_i == CP_UP) ? 8'h01 : 8'hFF;
    assign cp_load = shared_data_bus_i[DW-1:CPTR_LSB];
    dsrs_ptr #(.AW(CAW), .RST_A(CPA_INIT), .RST_B(CPB_INIT)) u_cptr (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .init_i(sample_start_i),
        .init_a_i(CPA_INIT),
        .init_b_i(CPB_INIT),
        .step_i(cp_step),
        .delta_i(cp_delta),
        .switch_i(coef_ptr_cmd_i == CP_SWITCH),
        .load_a_i(destination_select_field_i == DST_LOAD_CPA),
        .load_b_i(destination_select_field_i == DST_LOAD_CPB),
        .load_val_i(cp_load),
        .addr_o(caddr),
        .ptr_a_o(cp_a),
        .ptr_b_o(cp_b),
        .sel_b_o(cp_sel_b)
    );

    // ring start address moves on by one per sampling cycle
    assign run_start = sample_start_i && ring_mode_i;
    assign dp_init_a = ring_mode_i ? base_q : DPA_INIT;
    assign dp_init_b = ring_mode_i ? DAW'(base_q + DPB_INIT) : DPB_INIT;
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            base_q <= '0;
            start_q <= '0;
        end else if (sample_start_i) begin
            base_q <= run_start ? DAW'(base_q + RING_STEP) : base_q;
            start_q <= dp_init_a;
        end
    end

    // data pointers; a load is offset by the start address in ring mode
    assign dp_step = (data_ptr_cmd_i != DP_NOP) && (data_ptr_cmd_i != DP_SWITCH);
    assign load_off = ring_mode_i ? start_q : DPA_INIT;
    assign dp_load = DAW'(shared_data_bus_i[DW-1:DPTR_LSB] + load_off);
    dsrs_ptr #(.AW(DAW), .RST_A(DPA_INIT), .RST_B(DPB_INIT)) u_dptr (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .init_i(sample_start_i),
        .init_a_i(dp_init_a),
        .init_b_i(dp_init_b),
        .step_i(dp_step),
        .delta_i(dp_delta(data_ptr_cmd_i)),
        .switch_i(data_ptr_cmd_i == DP_SWITCH),
        .load_a_i(destination_select_field_i == DST_LOAD_DPA),
        .load_b_i(destination_select_field_i == DST_LOAD_DPB),
        .load_val_i(dp_load),
        .addr_o(daddr),
        .ptr_a_o(dp_a),
        .ptr_b_o(dp_b),
        .sel_b_o(dp_sel_b)
    );

    // running update: a window of words from the host at rising addresses
    assign accept = coef_load_we_i && ready_q;
    assign drain = resetn_i && hold_v_q && !coef_bus_wr;
    assign hold_v_d = accept || (hold_v_q && !drain);
    assign upd_cnt_d = coef_upd_start_i ? UPD_CW'(UPD_MAX)
                     : accept ? UPD_CW'(upd_cnt_q - 1'b1) : upd_cnt_q;
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            upd_cnt_q <= '0;
            upd_addr_q <= '0;
            hold_v_q <= 1'b0;
            hold_addr_q <= '0;
            hold_data_q <= '0;
            ready_q <= 1'b0;
        end else begin
            upd_cnt_q <= upd_cnt_d;
            upd_addr_q <= coef_upd_start_i ? coef_load_addr_i
                        : accept ? CAW'(upd_addr_q + 1'b1) : upd_addr_q;
            hold_v_q <= hold_v_d;
            hold_addr_q <= accept ? upd_addr_q : hold_addr_q;
            hold_data_q <= accept ? coefficient_load_bus_i : hold_data_q;
            ready_q <= (upd_cnt_d != '0) && !hold_v_d && !coef_upd_start_i;
        end
    end

    // coefficient memory port; bus write takes the current pointer
    assign bulk_wr = !resetn_i && coef_load_we_i;
    assign c_if.we = bulk_wr || coef_bus_wr || drain;
    assign c_if.waddr = bulk_wr ? coef_load_addr_i : coef_bus_wr ? caddr : hold_addr_q;
    assign c_if.wdata = bulk_wr ? coefficient_load_bus_i
                      : coef_bus_wr ? shared_data_bus_i[COEF_MSB:COEF_LSB] : hold_data_q;
    assign c_if.raddr = caddr;
    dsrs_ram #(.AW(CAW), .DW(CW)) u_coef_mem_write (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .port(c_if)
    );

    // data memory port, written only from the bus
    assign d_if.we = data_bus_wr;
    assign d_if.waddr = daddr;
    assign d_if.wdata = shared_data_bus_i;
    assign d_if.raddr = daddr;
    dsrs_ram #(.AW(DAW), .DW(DW)) u_dram (
        .sys_clk_i(sys_clk_i),
        .resetn_i(resetn_i),
        .port(d_if)
    );

    // bus source selection, zero when idle or in reset
    assign scr_out = scr_q[src_sel];
    assign coef_wide = {c_if.rdata, COEF_LOW_FILL};
    assign bus_mux = src_scr ? scr_out
                   : (source_select_field_i == SRC_COEF) ? coef_wide
                   : (source_select_field_i == SRC_DATA) ? d_if.rdata : '0;
    assign shared_data_bus_o = resetn_i ? bus_mux : '0;

    // operands straight from the memory output registers
    assign multiplier_coef_input_o = c_if.rdata;
    assign multiplier_data_input_o = d_if.rdata;
    assign coef_load_ready_o = ready_q;

    // checks
    logic [2:0] past_dst;
    assign past_dst = dst_sel;

    scr_capture_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        dst_scr |=> scr_q[$past(past_dst)] == $past(shared_data_bus_i))
        else $error("scratch register missed bus capture");
    coef_fill_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        source_select_field_i == SRC_COEF |->
        shared_data_bus_o == {multiplier_coef_input_o, 8'h00})
        else $error("coefficient not placed high with zero fill");
    bus_idle_a: assert property (@(posedge sys_clk_i)
        (!resetn_i || source_select_field_i == SRC_NONE) |-> shared_data_bus_o == '0)
        else $error("bus not zero while idle");
    coef_init_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        sample_start_i |=> cp_a == 8'h00 && cp_b == 8'h80 && !cp_sel_b)
        else $error("coefficient pointers not restarted");
    coef_switch_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (coef_ptr_cmd_i == CP_SWITCH && !sample_start_i && !cp_sel_b &&
         destination_select_field_i != DST_LOAD_CPA)
        |=> cp_sel_b && cp_a == 8'($past(cp_a) + 8'h01))
        else $error("coefficient switch wrong");
    coef_down_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (coef_ptr_cmd_i == CP_DOWN && !sample_start_i &&
         destination_select_field_i != DST_LOAD_CPA &&
         destination_select_field_i != DST_LOAD_CPB)
        |=> caddr == 8'($past(caddr) - 8'h01))
        else $error("coefficient pointer did not step down");
    coef_wr_read_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        coef_bus_wr |=> multiplier_coef_input_o == $past(shared_data_bus_i[23:8]))
        else $error("coefficient write not readable next step");
    data_wr_read_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        data_bus_wr |=> multiplier_data_input_o == $past(shared_data_bus_i))
        else $error("data write not readable next step");
    data_up3_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (data_ptr_cmd_i == DP_UP3 && !sample_start_i &&
         destination_select_field_i != DST_LOAD_DPA &&
         destination_select_field_i != DST_LOAD_DPB)
        |=> daddr == 7'($past(daddr) + 7'h03))
        else $error("data pointer did not step by three");
    ring_base_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (sample_start_i && ring_mode_i) |=>
        base_q == 7'($past(base_q) + 7'h01) && dp_a == $past(base_q) && !dp_sel_b)
        else $error("ring start address not advanced");
    linear_init_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (sample_start_i && !ring_mode_i) |=> dp_a == 7'h00 && dp_b == 7'h40)
        else $error("linear data pointers not restarted");
    data_load_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (destination_select_field_i == DST_LOAD_DPA && !sample_start_i) |=>
        dp_a == 7'($past(shared_data_bus_i[23:17]) + $past(load_off)))
        else $error("data pointer load value wrong");
    data_switch_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (data_ptr_cmd_i == DP_SWITCH && !sample_start_i && !dp_sel_b &&
         destination_select_field_i != DST_LOAD_DPA)
        |=> dp_sel_b && dp_a == 7'($past(dp_a) + 7'h01))
        else $error("data switch wrong");
    coef_new_ptr_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (coef_ptr_cmd_i == CP_SWITCH && !sample_start_i && !cp_sel_b &&
         destination_select_field_i != DST_LOAD_CPB)
        |=> caddr == $past(cp_b))
        else $error("coefficient read not from new pointer");
    data_new_ptr_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (data_ptr_cmd_i == DP_SWITCH && !sample_start_i && !dp_sel_b &&
         destination_select_field_i != DST_LOAD_DPB)
        |=> daddr == $past(dp_b))
        else $error("data read not from new pointer");
    coef_load_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (destination_select_field_i == DST_LOAD_CPB && !sample_start_i) |=>
        cp_b == $past(shared_data_bus_i[23:16]))
        else $error("coefficient pointer load value wrong");
    coef_wrap_a: assert property (@(posedge sys_clk_i) disable iff (!resetn_i)
        (coef_ptr_cmd_i == CP_UP && caddr == 8'hFF && !sample_start_i &&
         destination_select_field_i != DST_LOAD_CPA &&
         destination_select_field_i != DST_LOAD_CPB) |=> caddr == 8'h00)
        else $error("coefficient pointer did not wrap");

    coef_switch_c: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
        coef_ptr_cmd_i == CP_SWITCH ##2 source_select_field_i == SRC_COEF);
    data_switch_c: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
        data_ptr_cmd_i == DP_SWITCH ##1 data_bus_wr);
    upd_window_c: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
        accept && upd_cnt_q == 5'h01);
    ring_load_c: cover property (@(posedge sys_clk_i) disable iff (!resetn_i)
        ring_mode_i && destination_select_field_i == DST_LOAD_DPB);
endmodule
`default_nettype wire

// ### dsrs_seq_model.sv
// far-side sequencer model: merges the block's bus drive with other sources
`timescale 1ns/1ns
`default_nettype none
module dsrs_seq_model (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic resetn_i,
    // mode request and other bus sources
    input wire logic mode_req_i,
    input wire logic ext_en_i,
    input wire logic [23:0] ext_val_i,
    input wire logic [23:0] blk_bus_i,
    // towards the block
    output logic ring_mode_o,
    output logic [23:0] bus_o
);
    // addressing mode only set while the block is held in reset
    always_ff @(posedge sys_clk_i) begin
        if (!resetn_i) begin
            ring_mode_o <= mode_req_i;
        end
    end
    // an enabled other source takes the bus in place of the block's drive
    assign bus_o = ext_en_i ? ext_val_i : blk_bus_i;
endmodule
`default_nettype wire

// ### tb.sv
// self-checking bench for the scratch and memory store
`timescale 1ns/1ns
`default_nettype none
module tb;
    import dsrs_pkg::*;
    logic clk, rstn, sst, ring, rm, lwe, ust, ext_en, rdy, on;
    dsrs_src_t src;
    dsrs_dst_t dst;
    dsrs_cptr_t cc;
    dsrs_dptr_t dc;
    logic [23:0] ext, bus_i, bus_o, md, bv, ed;
    logic [15:0] ldata, mc, ec;
    logic [7:0] laddr, wm;
    logic [15:0] cm[256];
    logic [23:0] dm[128];
    logic [23:0] sr[8];
    int n_errors, check_count, st, nst, csel, dsel, ca, da, i;
    int cp[2], dp[2];
    int ctab[4] = '{0, 1, 255, 1};
    int dtab[8] = '{0, 1, 2, 3, 127, 126, 125, 1};
    wire logic mode;

    dsrs_top dut_u (.sys_clk_i(clk), .resetn_i(rstn), .sample_start_i(sst),
        .ring_mode_i(mode), .source_select_field_i(src), .destination_select_field_i(dst),
        .coef_ptr_cmd_i(cc), .data_ptr_cmd_i(dc), .shared_data_bus_i(bus_i),
        .shared_data_bus_o(bus_o), .coef_load_we_i(lwe), .coef_upd_start_i(ust),
        .coef_load_addr_i(laddr), .coefficient_load_bus_i(ldata), .coef_load_ready_o(rdy),
        .multiplier_coef_input_o(mc), .multiplier_data_input_o(md));
    dsrs_seq_model seq_u (.sys_clk_i(clk), .resetn_i(rstn), .mode_req_i(ring),
        .ext_en_i(ext_en), .ext_val_i(ext), .blk_bus_i(bus_o), .ring_mode_o(mode),
        .bus_o(bus_i));

    // expected bus drive of the block
    function logic [23:0] eb();
        if (!rstn || src == SRC_NONE) return 24'h000000;
        if (src == SRC_COEF) return {ec, 8'h00};
        if (src == SRC_DATA) return ed;
        return sr[src-1];
    endfunction
    task chk(input string nm, input logic [23:0] e, input logic [23:0] g);
        check_count++;
        if (g !== e || $isunknown(g)) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    task stop_test();
        if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // reference model, one step per edge
    always @(posedge clk) begin
        if (!rstn) begin
            cp = '{0, 128}; dp = '{0, 64}; csel = 0; dsel = 0; st = 0; nst = 0;
            ec = 16'h0000; ed = 24'h000000; wm = 8'h00; rm = ring;
            if (lwe) cm[laddr] = ldata;
        end else begin
            bv = ext_en ? ext : eb();
            ca = cp[csel];
            da = dp[dsel];
            if (dst == DST_COEF_WR) cm[ca] = bv[23:8];
            if (dst == DST_DATA_WR) dm[da] = bv;
            ec = cm[ca];
            ed = dm[da];
            if (dst >= DST_SCR0 && dst <= DST_SCR7) begin
                sr[dst-1] = bv;
                wm[dst-1] = 1'b1;
            end
            if (sst) begin
                if (rm && nst > 0) st = (st + 1) % 128;
                nst++;
                cp = '{0, 128}; csel = 0; dp[0] = st; dp[1] = (st + 64) % 128; dsel = 0;
            end else begin
                cp[csel] = (cp[csel] + ctab[cc]) % 256;
                if (cc == CP_SWITCH) csel ^= 1;
                dp[dsel] = (dp[dsel] + dtab[dc]) % 128;
                if (dc == DP_SWITCH) dsel ^= 1;
                if (dst == DST_LOAD_CPA) cp[0] = bv[23:16];
                if (dst == DST_LOAD_CPB) cp[1] = bv[23:16];
                if (dst == DST_LOAD_DPA) dp[0] = (bv[23:17] + st) % 128;
                if (dst == DST_LOAD_DPB) dp[1] = (bv[23:17] + st) % 128;
            end
        end
    end
    // compare outputs mid-cycle
    always @(negedge clk) begin
        if (on) begin
            if (!$isunknown(ec)) chk("coef_out", {8'h00, ec}, {8'h00, mc});
            if (!$isunknown(ed)) chk("data_out", ed, md);
            chk("bus_out", eb(), bus_o);
        end
    end
    task rst(input logic r, input logic bulk);
        @(posedge clk);
        #1 rstn = 0; ring = r; src = SRC_NONE; dst = DST_NONE; cc = CP_NOP; dc = DP_NOP;
        sst = 0; ext_en = 1;
        for (i = 0; i < (bulk ? 256 : 2); i++) begin
            lwe = bulk; laddr = 8'(i); ldata = 16'($urandom);
            @(posedge clk);
            #1 chk("ready", 24'h0, {23'h0, rdy});
        end
        lwe = 0; rstn = 1;
    endtask
    task rnd(input int n, input logic fill);
        for (int k = 0; k < n; k++) begin
            @(posedge clk);
            #1 src = dsrs_src_t'(4'($urandom_range(10)));
            if (src >= SRC_SCR0 && src <= SRC_SCR7 && !wm[src-1]) src = SRC_NONE;
            dst = dsrs_dst_t'(4'($urandom_range(14)));
            cc = dsrs_cptr_t'(2'($urandom));
            dc = dsrs_dptr_t'(3'($urandom));
            ext = 24'($urandom);
            sst = ($urandom_range(15) == 0);
            if (dst == DST_LOAD_CPA || dst == DST_LOAD_CPB) cc = CP_NOP;
            if (dst == DST_LOAD_DPA || dst == DST_LOAD_DPB) dc = DP_NOP;
            if (fill) begin
                src = SRC_NONE; dst = DST_DATA_WR; dc = DP_UP1; cc = CP_NOP; sst = (k == 0);
            end
            ext_en = (src == SRC_NONE);
        end
    endtask
    task upd();
        @(posedge clk);
        #1 src = SRC_NONE; dst = DST_NONE; cc = CP_NOP; dc = DP_NOP; ext_en = 1;
        sst = 1; ust = 1; laddr = 8'h90;
        @(posedge clk);
        #1 sst = 0; ust = 0;
        @(posedge clk);
        #1;
        for (i = 0; i < 17; i++) begin
            chk("ready", {23'h0, i < 16}, {23'h0, rdy});
            lwe = 1; ldata = 16'($urandom);
            if (i < 16) cm[144+i] = ldata;
            @(posedge clk);
            #1 lwe = 0;
            chk("ready", 24'h0, {23'h0, rdy});
            @(posedge clk);
            #1;
        end
        ext = 24'h8F0000; dst = DST_LOAD_CPA;
        @(posedge clk);
        #1 dst = DST_NONE; cc = CP_UP;
        repeat (20) @(posedge clk);
        #1 cc = CP_NOP;
    endtask
    // clock
    initial begin
        clk = 0;
        forever #20 clk = ~clk;
    end
    // watchdog
    initial begin
        #(40 * 5000);
        n_errors++;
        stop_test();
    end
    // main sequence
    initial begin
        n_errors = 0; check_count = 0; on = 0; rstn = 0; ring = 0; sst = 0; lwe = 0; ust = 0;
        ext_en = 1; ext = 24'h000000; laddr = 8'h00; ldata = 16'h0000; src = SRC_NONE;
        dst = DST_NONE; cc = CP_NOP; dc = DP_NOP;
        void'($urandom(64));
        repeat (2) @(posedge clk);
        #1 rstn = 1; on = 1;
        rst(0, 1);
        rnd(130, 1);
        rnd(800, 0);
        upd();
        rst(1, 0);
        rnd(800, 0);
        stop_test();
    end
endmodule
`default_nettype wire
